// >>> cso_pkg.sv
// Function
// - output high while selected condition active
// - acquiring stays low through start cleans, rises at exposure
// - acquiring held in focus, drops after frames
// - interline shift high for whole shift
// - full-frame shift pulses once per line
// - frame-transfer shift high during transfer
// - constant source holds output high
// - readout source high during readout only
// - shutter source high during exposure while gate on
// - trigger wait high while armed, falls when trigger starts exposure
// - trigger wait rises after cleans, exposure, readout or pre-open
// - continuous cleans poll trigger before each clean
// - invert setting drives output low when active
// - frames sum accumulations, exposures equal product
// - gain accepts integers 1 to 100
// - gate mode pulses bias, safe mode off
`default_nettype none
package cso_pkg;
   // ======================================================
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS       = 1000;
   localparam int TICK_DIV      = (TICK_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int CLEAN_US      = 100;
   localparam int PREOPEN_US    = 20;
   localparam logic [15:0] CLEAN_TICKS   = 16'(CLEAN_US * 1000 / TICK_NS);
   localparam logic [15:0] PREOPEN_TICKS = 16'(PREOPEN_US * 1000 / TICK_NS);
   localparam logic [1:0]  CLEAN_N       = 2'h2;
   // ======================================================
   // register offsets
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_CMD    = 8'h04;
   localparam logic [7:0] A_FRAMES = 8'h08;
   localparam logic [7:0] A_ACCUM  = 8'h0c;
   localparam logic [7:0] A_EXPOSE = 8'h10;
   localparam logic [7:0] A_LINES  = 8'h14;
   localparam logic [7:0] A_GAIN   = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1c;
   localparam logic [7:0] A_FCOUNT = 8'h20;
   localparam logic [7:0] A_ECOUNT = 8'h24;
   // ======================================================
   // control fields
   localparam int F_SRC_LO  = 0;
   localparam int F_INV     = 3;
   localparam int F_SEN_LO  = 4;
   localparam int F_FOCUS   = 6;
   localparam int F_TRIG    = 7;
   localparam int F_CCLEAN  = 8;
   localparam int F_PREOPEN = 9;
   localparam int F_GATE    = 10;
   localparam int F_START   = 0;
   localparam int F_HALT    = 1;
   // ======================================================
   // reset values
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] FRAMES_RST = 16'h0001;
   localparam logic [15:0] ACCUM_RST  = 16'h0001;
   localparam logic [15:0] EXPOSE_RST = 16'h000a;
   localparam logic [15:0] LINES_RST  = 16'h0010;
   localparam logic [6:0]  GAIN_RST   = 7'h01;
   localparam logic [6:0]  GAIN_MIN   = 7'h01;
   localparam logic [6:0]  GAIN_MAX   = 7'h64;
   // ======================================================
   // enumerations
   typedef enum logic [2:0] {
      SRC_ACQ   = 3'h0,
      SRC_SHIFT = 3'h1,
      SRC_ONE   = 3'h2,
      SRC_READ  = 3'h3,
      SRC_SHUT  = 3'h4,
      SRC_WAIT  = 3'h5
   } cso_src_t;
   localparam logic [1:0] SEN_INTERLINE = 2'h0;
   localparam logic [1:0] SEN_FULLFRAME = 2'h1;
   localparam logic [1:0] SEN_FRAMEXFER = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_CLEAN   = 3'h1,
      ST_WAIT    = 3'h3,
      ST_EXPOSE  = 3'h2,
      ST_SHIFT   = 3'h6,
      ST_READ    = 3'h7,
      ST_PREOPEN = 3'h5,
      ST_CCLEAN  = 3'h4
   } cso_state_t;
   typedef struct packed {
      logic s1;
      logic s2;
   } cso_sync_t;
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } cso_tick_t;
endpackage : cso_pkg
`default_nettype wire

// >>> cso_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cso_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // level
   input  wire logic d,
   output logic      q
);
   import cso_pkg::*;
   cso_sync_t r;
   cso_sync_t r_nxt;
   always_comb begin
      r_nxt    = r;
      r_nxt.s1 = d;
      r_nxt.s2 = r.s1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end
   assign q = r.s2;
endmodule : cso_sync
`default_nettype wire

// >>> cso_top.sv
`timescale 1ns/1ps
`default_nettype none
module cso_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // camera pins
   input  wire logic        ext_trig,
   output logic             logic_out,
   output logic             intens_bias,
   output logic [6:0]       gain_level
);
   import cso_pkg::*;
   // ======================================================
   // state
   typedef struct packed {
      cso_state_t  st;
      logic [15:0] ctrl;
      logic [15:0] frames;
      logic [15:0] accum;
      logic [15:0] expo;
      logic [15:0] lines;
      logic [6:0]  gain;
      logic [15:0] cnt;
      logic [1:0]  ncl;
      logic [15:0] fdone;
      logic [15:0] adone;
      logic [31:0] etot;
      logic        trig_seen;
      logic        trig_d;
      logic        acq;
      logic        out;
      logic        bias;
      logic        pready;
      logic        slverr;
      logic [31:0] rdata;
   } cso_top_t;
   cso_top_t r;
   cso_top_t r_nxt;
   logic     trig_s;
   logic     done;
   logic     cmd_start;
   logic     cmd_halt;
   logic     gain_ok;
   logic     armed;
   cso_src_t src;
   logic     inv;
   logic     gate;
   logic [1:0] sen;
   logic     tick;
   // ======================================================
   // trigger pin synchroniser
   cso_sync u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (ext_trig),
      .q     (trig_s)
   );
   // ======================================================
   // microsecond enable
   cso_tick u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (tick)
   );
   // ======================================================
   // decode
   assign done      = psel & penable & r.pready;
   assign cmd_start = done & pwrite & (paddr == A_CMD) & pwdata[F_START];
   assign cmd_halt  = done & pwrite & (paddr == A_CMD) & pwdata[F_HALT];
   assign gain_ok   = (r.st == ST_IDLE)
                    & (pwdata[31:7] == 25'h0)
                    & (pwdata[6:0] >= GAIN_MIN)
                    & (pwdata[6:0] <= GAIN_MAX);
   assign armed     = (r.st == ST_WAIT) | (r.st == ST_CCLEAN);
   assign src       = cso_src_t'(r.ctrl[F_SRC_LO +: 3]);
   assign inv       = r.ctrl[F_INV];
   assign gate      = r.ctrl[F_GATE];
   assign sen       = r.ctrl[F_SEN_LO +: 2];
   // ======================================================
   // next state
   always_comb begin
      logic        adv;
      logic        go_next;
      logic        go_exp;
      logic        hit;
      logic        cond;
      logic [31:0] rd;
      logic [15:0] a1;
      logic [15:0] f1;
      adv     = 1'b0;
      go_next = 1'b0;
      go_exp  = 1'b0;
      hit     = 1'b1;
      cond    = 1'b0;
      rd      = 32'h0;
      a1      = 16'(r.adone + 16'h0001);
      f1      = 16'(r.fdone + 16'h0001);
      r_nxt   = r;
      // apb read and answer
      unique case (paddr)
         A_CTRL:   rd = {16'h0, r.ctrl};
         A_CMD:    rd = 32'h0;
         A_FRAMES: rd = {16'h0, r.frames};
         A_ACCUM:  rd = {16'h0, r.accum};
         A_EXPOSE: rd = {16'h0, r.expo};
         A_LINES:  rd = {16'h0, r.lines};
         A_GAIN:   rd = {25'h0, r.gain};
         A_STATUS: rd = {27'h0, r.trig_seen, r.acq, r.st};
         A_FCOUNT: rd = {16'h0, r.fdone};
         A_ECOUNT: rd = r.etot;
         default:  hit = 1'b0;
      endcase
      r_nxt.pready = psel & penable & ~r.pready;
      r_nxt.slverr = 1'b0;
      r_nxt.rdata  = 32'h0;
      if (psel & penable & ~r.pready) begin
         r_nxt.slverr = ~hit | (pwrite & (paddr == A_GAIN) & ~gain_ok);
         if (!pwrite) begin
            r_nxt.rdata = rd;
         end
      end
      if (done & pwrite) begin
         unique case (paddr)
            A_CTRL:   r_nxt.ctrl   = pwdata[15:0];
            A_FRAMES: r_nxt.frames = pwdata[15:0];
            A_ACCUM:  r_nxt.accum  = pwdata[15:0];
            A_EXPOSE: r_nxt.expo   = pwdata[15:0];
            A_LINES:  r_nxt.lines  = pwdata[15:0];
            A_GAIN: begin
               if (gain_ok) begin
                  r_nxt.gain = pwdata[6:0];
               end
            end
            default: ;
         endcase
      end
      // state timer
      if (tick) begin
         if (r.cnt <= 16'h0001) begin
            adv = 1'b1;
         end else begin
            r_nxt.cnt = 16'(r.cnt - 16'h0001);
         end
      end
      // trigger latch while armed
      r_nxt.trig_d = trig_s;
      if (armed & trig_s & ~r.trig_d) begin
         r_nxt.trig_seen = 1'b1;
      end
      // sequencer
      unique case (r.st)
         ST_IDLE: begin
            if (cmd_start) begin
               r_nxt.st    = ST_CLEAN;
               r_nxt.cnt   = CLEAN_TICKS;
               r_nxt.ncl   = 2'h0;
               r_nxt.fdone = 16'h0;
               r_nxt.adone = 16'h0;
               r_nxt.etot  = 32'h0;
            end
         end
         ST_CLEAN: begin
            if (adv) begin
               if (r.ncl == 2'(CLEAN_N - 2'h1)) begin
                  go_next = 1'b1;
               end else begin
                  r_nxt.ncl = 2'(r.ncl + 2'h1);
                  r_nxt.cnt = CLEAN_TICKS;
               end
            end
         end
         ST_WAIT: begin
            if (r.trig_seen) begin
               go_exp = 1'b1;
            end else if (r.ctrl[F_CCLEAN]) begin
               r_nxt.st  = ST_CCLEAN;
               r_nxt.cnt = CLEAN_TICKS;
            end
         end
         ST_CCLEAN: begin
            if (adv) begin
               r_nxt.st = ST_WAIT;
            end
         end
         ST_EXPOSE: begin
            if (adv) begin
               if (a1 >= r.accum) begin
                  r_nxt.st  = ST_SHIFT;
                  r_nxt.cnt = r.lines;
                  r_nxt.adone = 16'h0;
               end else begin
                  r_nxt.adone = a1;
                  go_next     = 1'b1;
               end
            end
         end
         ST_SHIFT: begin
            if (adv) begin
               r_nxt.st  = ST_READ;
               r_nxt.cnt = r.lines;
            end
         end
         ST_READ: begin
            if (adv) begin
               r_nxt.fdone = f1;
               if (!r.ctrl[F_FOCUS] && (f1 >= r.frames)) begin
                  r_nxt.st  = ST_IDLE;
                  r_nxt.acq = 1'b0;
               end else begin
                  go_next = 1'b1;
               end
            end
         end
         ST_PREOPEN: begin
            if (adv) begin
               r_nxt.st = ST_WAIT;
            end
         end
      endcase
      if (go_next) begin
         if (r.ctrl[F_TRIG] && r.ctrl[F_PREOPEN]) begin
            r_nxt.st  = ST_PREOPEN;
            r_nxt.cnt = PREOPEN_TICKS;
         end else if (r.ctrl[F_TRIG]) begin
            r_nxt.st = ST_WAIT;
         end else begin
            go_exp = 1'b1;
         end
      end
      if (go_exp) begin
         r_nxt.st        = ST_EXPOSE;
         r_nxt.cnt       = r.expo;
         r_nxt.acq       = 1'b1;
         r_nxt.trig_seen = armed & trig_s & ~r.trig_d;
         r_nxt.etot      = 32'(r.etot + 32'h1);
      end
      if (cmd_halt) begin
         r_nxt.st        = ST_IDLE;
         r_nxt.acq       = 1'b0;
         r_nxt.trig_seen = 1'b0;
      end
      // status output mux, registered so it cannot glitch
      unique case (src)
         SRC_ACQ:   cond = r.acq;
         SRC_SHIFT: begin
            if (sen == SEN_FULLFRAME) begin
               cond = (r.st == ST_SHIFT) & tick;
            end else begin
               cond = (r.st == ST_SHIFT);
            end
         end
         SRC_ONE:   cond = 1'b1;
         SRC_READ:  cond = (r.st == ST_READ);
         SRC_SHUT:  cond = (r.st == ST_EXPOSE) & gate;
         SRC_WAIT:  cond = armed;
         default:   cond = 1'b0;
      endcase
      r_nxt.out  = cond ^ inv;
      r_nxt.bias = gate & (r.st == ST_EXPOSE);
   end
   // ======================================================
   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r        <= '0;
         r.st     <= ST_IDLE;
         r.ctrl   <= CTRL_RST;
         r.frames <= FRAMES_RST;
         r.accum  <= ACCUM_RST;
         r.expo   <= EXPOSE_RST;
         r.lines  <= LINES_RST;
         r.gain   <= GAIN_RST;
      end else begin
         r <= r_nxt;
      end
   end
   assign prdata      = r.rdata;
   assign pready      = r.pready;
   assign pslverr     = r.slverr;
   assign logic_out   = r.out;
   assign intens_bias = r.bias;
   assign gain_level  = r.gain;
   // ======================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_ONE_HIGH: assert property (
      (src == SRC_ONE) && !inv |=> logic_out)
      else $error("constant source not high");
   AST_READ_MUX: assert property (
      (src == SRC_READ) |=>
      (logic_out == ($past(r.st == ST_READ) ^ $past(inv))))
      else $error("readout source wrong");
   AST_CLEAN_LOW: assert property (
      (r.st == ST_CLEAN) |-> !r.acq)
      else $error("acquiring high during clean");
   AST_ACQ_RISE: assert property (
      $rose(r.acq) |-> (r.st == ST_EXPOSE))
      else $error("acquiring rose outside exposure");
   AST_FOCUS_HOLD: assert property (
      r.acq && r.ctrl[F_FOCUS] && !cmd_halt |=> r.acq)
      else $error("acquiring dropped in focus");
   AST_POLL: assert property (
      (r.st == ST_WAIT) && r.ctrl[F_CCLEAN] && !r.trig_seen
      && !cmd_halt |=> (r.st == ST_CCLEAN) ##[1:1000] (r.st != ST_CCLEAN))
      else $error("continuous clean poll broken");
   AST_WAIT_FALL: assert property (
      (r.st == ST_WAIT) && r.trig_seen && !cmd_halt
      |=> (r.st == ST_EXPOSE) && !armed)
      else $error("trigger did not start exposure");
   AST_GAIN_RANGE: assert property (
      (r.gain >= GAIN_MIN) && (r.gain <= GAIN_MAX))
      else $error("gain out of range");
   AST_GAIN_STOP: assert property (
      $changed(r.gain) |-> $past(r.st) == ST_IDLE)
      else $error("gain changed while running");
   AST_SAFE_BIAS: assert property (
      !gate ##1 !gate |-> !intens_bias)
      else $error("bias on in safe mode");
   AST_FF_PULSE: assert property (
      (src == SRC_SHIFT) && (sen == SEN_FULLFRAME) && !inv
      && $stable(r.ctrl) && logic_out |=> !logic_out)
      else $error("full-frame shift pulse too long");
   AST_SHIFT_HOLD: assert property (
      (src == SRC_SHIFT) && (sen != SEN_FULLFRAME) |=>
      (logic_out == ($past(r.st == ST_SHIFT) ^ $past(inv))))
      else $error("shift source wrong");
   AST_WFT_ENTRY: assert property (
      (r.st != ST_WAIT) ##1 (r.st == ST_WAIT) |->
      $past(r.st) inside {ST_READ, ST_PREOPEN, ST_CLEAN, ST_CCLEAN,
                          ST_EXPOSE})
      else $error("trigger wait entered from wrong state");
endmodule : cso_top
`default_nettype wire

// >>> cso_tick.sv
`timescale 1ns/1ps
`default_nettype none
module cso_tick (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // enable
   output logic      tick
);
   import cso_pkg::*;
   cso_tick_t r;
   cso_tick_t r_nxt;
   always_comb begin
      r_nxt      = r;
      r_nxt.tick = 1'b0;
      if (r.cnt == 8'(TICK_DIV - 1)) begin
         r_nxt.cnt  = 8'h00;
         r_nxt.tick = 1'b1;
      end else begin
         r_nxt.cnt = 8'(r.cnt + 8'h01);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end
   assign tick = r.tick;
endmodule : cso_tick
`default_nettype wire

// >>> cso_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// external trigger source: a pulse on request, low when idle
module cso_trig_src (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // request
   input  wire logic fire,
   // pin
   output logic      ext_trig
);
   logic [4:0] hold_r;

   // pulse held for twenty cycles so the two-stage sync sees it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         hold_r <= 5'h00;
      else if (fire)
         hold_r <= 5'h14;
      else if (hold_r != 5'h00)
         hold_r <= hold_r - 5'h01;
   end

   assign ext_trig = (hold_r != 5'h00);
endmodule : cso_trig_src
`default_nettype wire

// >>> test_camera_status_output_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_camera_status_output_select;
   import cso_pkg::*;
   localparam logic [31:0] LN = 32'h2;
   localparam logic [31:0] GT = 32'h1 << F_GATE;
   localparam logic [31:0] IV = 32'h1 << F_INV;
   localparam logic [31:0] TR = 32'h1 << F_TRIG;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_trig;
   logic        fire = 1'b0;
   logic        logic_out;
   logic        intens_bias;
   logic [6:0]  gain_level;
   logic        lo_q = 1'b0;
   logic        bi_q = 1'b0;
   int          rises = 0;
   int          brises = 0;
   int          bad_count = 0;
   int          cmp_count = 0;

   // ======================================================
   // clock, design, partner
   always #50 clk = ~clk;

   cso_top u_dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_trig(ext_trig),
      .logic_out(logic_out), .intens_bias(intens_bias),
      .gain_level(gain_level)
   );

   cso_trig_src u_trig (
      .clk(clk), .rst_n(rst_n), .fire(fire), .ext_trig(ext_trig)
   );

   // ======================================================
   // edge counters on the status line and the bias line
   always @(negedge clk) begin
      lo_q <= logic_out;
      bi_q <= intens_bias;
      if (logic_out === 1'b1 && lo_q === 1'b0)
         rises <= rises + 1;
      if (intens_bias === 1'b1 && bi_q === 1'b0)
         brises <= brises + 1;
   end

   // ======================================================
   // tasks
   task summarize;
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk

   task settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d, input logic x);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
      chk(32'(e), 32'(x));
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk(32'(e), 32'(xe));
   endtask : rdchk

   task wst(input logic [2:0] s);
      int          n;
      logic [31:0] r;
      logic        e;
      n = 0;
      do begin
         xfer(1'b0, A_STATUS, 32'h0, r, e);
         n++;
      end while (r[2:0] !== s && n < 3000);
      if (n >= 3000) begin
         bad_count++;
         summarize();
      end
      settle(2);
   endtask : wst

   task run(input logic [31:0] c, input logic [31:0] f,
            input logic [31:0] ac, input logic [31:0] er,
            input logic [31:0] eb);
      int r0;
      int b0;
      wr(A_CTRL, c, 1'b0);
      wr(A_FRAMES, f, 1'b0);
      wr(A_ACCUM, ac, 1'b0);
      wr(A_EXPOSE, 32'h2, 1'b0);
      wr(A_LINES, LN, 1'b0);
      r0 = rises;
      b0 = brises;
      wr(A_CMD, 32'h1, 1'b0);
      settle(500);
      chk(32'(logic_out), 32'(c[F_INV]));
      wst(ST_IDLE);
      chk(32'(rises - r0), er);
      chk(32'(brises - b0), eb);
      chk(32'(logic_out), 32'(c[F_INV]));
   endtask : run

   // ======================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(A_CTRL, 32'(CTRL_RST), 1'b0);
      rdchk(A_FRAMES, 32'(FRAMES_RST), 1'b0);
      rdchk(A_LINES, 32'(LINES_RST), 1'b0);
      rdchk(A_GAIN, 32'(GAIN_RST), 1'b0);
      rdchk(8'hfc, 32'h0, 1'b1);
      wr(A_GAIN, 32'h0, 1'b1);
      wr(A_GAIN, 32'h65, 1'b1);
      wr(A_GAIN, 32'h64, 1'b0);
      settle(1);
      chk(32'(gain_level), 32'(GAIN_MAX));
      wr(A_CTRL, 32'(SRC_ONE), 1'b0);
      settle(2);
      chk(32'(logic_out), 32'h1);
      wr(A_CTRL, 32'(SRC_ONE) | IV, 1'b0);
      settle(2);
      chk(32'(logic_out), 32'h0);
      run(32'(SRC_ACQ), 32'h2, 32'h2, 32'h1, 32'h0);
      rdchk(A_ECOUNT, 32'h4, 1'b0);
      rdchk(A_FCOUNT, 32'h2, 1'b0);
      run(32'(SRC_SHIFT), 32'h2, 32'h1, 32'h2, 32'h0);
      run(32'(SRC_SHIFT) | (32'(SEN_FULLFRAME) << F_SEN_LO),
          32'h2, 32'h1, 32'h2 * LN, 32'h0);
      run(32'(SRC_SHIFT) | (32'(SEN_FRAMEXFER) << F_SEN_LO),
          32'h2, 32'h1, 32'h2, 32'h0);
      run(32'(SRC_READ), 32'h2, 32'h1, 32'h2, 32'h0);
      run(32'(SRC_READ) | IV, 32'h2, 32'h1, 32'h2, 32'h0);
      run(32'(SRC_SHUT) | GT, 32'h2, 32'h1, 32'h2, 32'h2);
      run(32'(SRC_SHUT), 32'h1, 32'h1, 32'h0, 32'h0);
      // armed wait with pre-open, then a trigger
      wr(A_FRAMES, 32'h1, 1'b0);
      wr(A_CTRL, 32'(SRC_WAIT) | TR | (32'h1 << F_PREOPEN), 1'b0);
      wr(A_CMD, 32'h1, 1'b0);
      wst(ST_PREOPEN);
      chk(32'(logic_out), 32'h0);
      wst(ST_WAIT);
      chk(32'(logic_out), 32'h1);
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      wst(ST_EXPOSE);
      chk(32'(logic_out), 32'h0);
      wst(ST_IDLE);
      // continuous cleans: trigger honoured only after a whole clean
      wr(A_CTRL, 32'(SRC_WAIT) | TR | (32'h1 << F_CCLEAN), 1'b0);
      wr(A_CMD, 32'h1, 1'b0);
      wst(ST_CCLEAN);
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      settle(300);
      rdchk(A_STATUS, 32'h10 | 32'(ST_CCLEAN), 1'b0);
      wst(ST_EXPOSE);
      wst(ST_IDLE);
      // focus: stays high until halted, gain locked while running
      wr(A_CTRL, 32'(SRC_ACQ) | (32'h1 << F_FOCUS), 1'b0);
      wr(A_CMD, 32'h1, 1'b0);
      wst(ST_EXPOSE);
      settle(600);
      chk(32'(logic_out), 32'h1);
      wr(A_GAIN, 32'h32, 1'b1);
      chk(32'(gain_level), 32'(GAIN_MAX));
      wr(A_CMD, 32'h2, 1'b0);
      settle(3);
      chk(32'(logic_out), 32'h0);
      wr(A_GAIN, 32'h32, 1'b0);
      settle(1);
      chk(32'(gain_level), 32'h32);
      summarize();
   end
endmodule : test_camera_status_output_select
`default_nettype wire
